// ===== hdl/flash_bus_if.sv
`timescale 1ns/10ps
interface flash_bus_if;
  import flash_ctl_pkg::*;
  logic              ctl_we;
  logic [7:0]        ctl_wdata;
  logic [7:0]        ctl_rdata;
  logic              arr_we;
  logic              arr_re;
  logic [ADDR_W-1:0] arr_addr;
  logic [DATA_W-1:0] arr_wdata;
  logic [DATA_W-1:0] arr_rdata;
  logic              test_high_voltage;

  modport device (
    input  ctl_we,
    input  ctl_wdata,
    output ctl_rdata,
    input  arr_we,
    input  arr_re,
    input  arr_addr,
    input  arr_wdata,
    output arr_rdata,
    input  test_high_voltage
  );
  modport host (
    output ctl_we,
    output ctl_wdata,
    input  ctl_rdata,
    output arr_we,
    output arr_re,
    output arr_addr,
    output arr_wdata,
    input  arr_rdata,
    output test_high_voltage
  );
endinterface : flash_bus_if

// ===== hdl/flash_ctl_pkg.sv
package flash_ctl_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ARRAY_BYTES = 8192;
  localparam int unsigned PAGE_BYTES  = 64;
  localparam int unsigned ROW_BYTES   = 32;
  localparam logic [15:0] ARRAY_BASE  = 16'he000;
  localparam logic [15:0] PROTECT_ADDR = 16'hff7e;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [7:0]  OPEN_PROTECT = 8'hff;
  localparam logic [1:0]  PROT_HIGH_BITS = 2'h3;
  localparam logic [5:0]  PROT_LOW_BITS  = 6'h00;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned CTL_PROGRAM = 0;
  localparam int unsigned CTL_ERASE   = 1;
  localparam int unsigned CTL_WHOLE   = 2;
  localparam int unsigned CTL_HV      = 3;
  localparam logic [7:0]  CTL_RESET   = 8'h00;

  // ****************************************************************
  // Software command port of the controller
  // ****************************************************************
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_DATA   = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  localparam logic [3:0] REG_PROT   = 4'h5;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h01;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h02;
  localparam logic [7:0] CMD_PROGRAM    = 8'h03;
  localparam logic [7:0] CMD_READ       = 8'h04;
  localparam logic [7:0] CMD_LONG_ERASE = 8'h80;

  // ****************************************************************
  // Timing, 250 MHz reference clock
  // ****************************************************************
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned NVS_US          = 10;
  localparam int unsigned NVH_US          = 5;
  localparam int unsigned NVHL_US         = 100;
  localparam int unsigned PGS_US          = 5;
  localparam int unsigned PROG_US         = 30;
  localparam int unsigned RCV_US          = 1;
  localparam int unsigned ERASE_SHORT_US  = 1000;
  localparam int unsigned ERASE_LONG_US   = 4000;
  localparam int unsigned MERASE_US       = 4000;
  localparam int unsigned NVS_CYC    = NVS_US * CLK_MHZ;
  localparam int unsigned NVH_CYC    = NVH_US * CLK_MHZ;
  localparam int unsigned NVHL_CYC   = NVHL_US * CLK_MHZ;
  localparam int unsigned PGS_CYC    = PGS_US * CLK_MHZ;
  localparam int unsigned PROG_CYC   = PROG_US * CLK_MHZ;
  localparam int unsigned RCV_CYC    = RCV_US * CLK_MHZ;
  localparam int unsigned ESHORT_CYC = ERASE_SHORT_US * CLK_MHZ;
  localparam int unsigned ELONG_CYC  = ERASE_LONG_US * CLK_MHZ;
  localparam int unsigned MERASE_CYC = MERASE_US * CLK_MHZ;
  localparam int unsigned CNT_W      = 24;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } acc_kind_t;

endpackage : flash_ctl_pkg

// ===== hdl/flash_device.sv
`timescale 1ns/10ps
module flash_device
  import flash_ctl_pkg::*;
#(
  parameter int unsigned BYTES = ARRAY_BYTES
)
(
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  // Link to the software side
  flash_bus_if.device bus,
  // Observed state
  output logic [7:0] flash_operation_control,
  output logic [7:0] protect_start_byte
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0]  mem [BYTES];
  logic        armed;
  logic [15:0] target;
  logic [15:0] prot_start;
  logic        in_array;
  logic        locked;
  logic        hv_ok;
  logic        prog_sel;
  logic        erase_sel;
  logic        whole_sel;
  logic        hv;
  logic [12:0] idx;
  logic [7:0]  next_ctl;
  logic        prot_active;
  logic        in_prot_range;
  logic        prot_byte_hit;
  logic        mass_block;
  logic        erase_page;
  logic        erase_all;
  logic        prog_write;
  logic [7:0]  rd_value;

  // Upper four bits read as zero and ignore writes
  localparam logic [7:0] CTL_WRITABLE = 8'((1 << CTL_PROGRAM) | (1 << CTL_ERASE) |
                                           (1 << CTL_WHOLE) | (1 << CTL_HV));

  assign prog_sel  = flash_operation_control[CTL_PROGRAM];
  assign erase_sel = flash_operation_control[CTL_ERASE];
  assign whole_sel = flash_operation_control[CTL_WHOLE];
  assign hv        = flash_operation_control[CTL_HV];
  assign in_array  = bus.arr_addr >= ARRAY_BASE;
  assign idx       = bus.arr_addr[12:0];

  // Protect start: high bits ones, low six zeros
  assign prot_start = {PROT_HIGH_BITS, protect_start_byte, PROT_LOW_BITS};

  // ****************************************************************
  // Block protection
  // ****************************************************************
  // Any value but all ones switches protection on; zero covers all
  assign prot_active   = (protect_start_byte != OPEN_PROTECT);
  assign in_prot_range = (target >= prot_start);
  // At FE the protect byte lies below its own range but is locked as well
  assign prot_byte_hit = (target == PROTECT_ADDR);
  assign mass_block    = erase_sel && whole_sel && prot_active;

  // Only the external test voltage lifts a lock
  assign locked = !bus.test_high_voltage && prot_active && (in_prot_range || prot_byte_hit);

  always_comb
  begin
    hv_ok = armed && (prog_sel || erase_sel) && !locked;
    if (mass_block && !bus.test_high_voltage)
      hv_ok = 1'b0;
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_comb
  begin
    next_ctl = bus.ctl_wdata & CTL_WRITABLE;
    // Refuse both selects; keep old select bits
    if (next_ctl[CTL_PROGRAM] && next_ctl[CTL_ERASE])
    begin
      next_ctl[CTL_PROGRAM] = prog_sel;
      next_ctl[CTL_ERASE]   = erase_sel;
    end
    // High voltage only rises when allowed
    if (next_ctl[CTL_HV] && !hv && !hv_ok)
      next_ctl[CTL_HV] = 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      flash_operation_control <= CTL_RESET;
    else if (bus.ctl_we)
      flash_operation_control <= next_ctl;
  end

  // ****************************************************************
  // Arming: each array write with HV off after a select latches target
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      armed <= 1'b0;
    else if (!prog_sel && !erase_sel)
      armed <= 1'b0;
    else if (bus.arr_we && !hv && in_array)
      armed <= 1'b1;
  end

  // The arming write names the page or row the operation acts on
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      target <= '0;
    else if ((prog_sel || erase_sel) && bus.arr_we && !hv && in_array)
      target <= bus.arr_addr;
  end

  // ****************************************************************
  // Array behaviour. Erase/program act when HV is on, modelled as
  // instant cell changes; timing is left to the sequencing side.
  // ****************************************************************
  assign erase_page = hv && erase_sel && !whole_sel && armed;
  assign erase_all  = hv && erase_sel && whole_sel && armed;
  // A program write only lands inside the armed row
  assign prog_write = hv && prog_sel && bus.arr_we && in_array &&
                      (bus.arr_addr[15:5] == target[15:5]);

  always_ff @(posedge ref_clk)
  begin
    if (erase_page)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        mem[{target[12:6], 6'(i)}] <= ERASED_BYTE;
    end
    else if (erase_all)
    begin
      for (int i = 0; i < BYTES; i++)
        mem[i] <= ERASED_BYTE;
    end
    else if (prog_write)
      mem[idx] <= mem[idx] & bus.arr_wdata;
  end

  // Protect byte mirrors its array location; open after reset
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      protect_start_byte <= OPEN_PROTECT;
    else if (!locked && (erase_all || (erase_page && (target[15:6] == PROTECT_ADDR[15:6]))))
      protect_start_byte <= ERASED_BYTE;
    else if (prog_write && (bus.arr_addr == PROTECT_ADDR))
      protect_start_byte <= protect_start_byte & bus.arr_wdata;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // The protect byte answers at its own address from the mirror
  always_comb
  begin
    rd_value = '0;
    if (bus.arr_addr == PROTECT_ADDR)
      rd_value = protect_start_byte;
    else if (in_array)
      rd_value = mem[idx];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      bus.arr_rdata <= '0;
    else if (bus.arr_re)
      bus.arr_rdata <= rd_value;
  end

  assign bus.ctl_rdata = flash_operation_control;
endmodule : flash_device

// ===== hdl/flash_host.sv
`timescale 1ns/10ps
module flash_host
  import flash_ctl_pkg::*;
#(
  parameter int unsigned NVS_N   = NVS_CYC,
  parameter int unsigned NVH_N   = NVH_CYC,
  parameter int unsigned NVHL_N  = NVHL_CYC,
  parameter int unsigned PGS_N   = PGS_CYC,
  parameter int unsigned PROG_N  = PROG_CYC,
  parameter int unsigned RCV_N   = RCV_CYC,
  parameter int unsigned ESHORT_N = ESHORT_CYC,
  parameter int unsigned ELONG_N  = ELONG_CYC,
  parameter int unsigned MERASE_N = MERASE_CYC
)
(
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  // Software port
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_we,
  input  wire logic       sw_re,
  output logic [7:0]      sw_rdata,
  // Test voltage request
  input  wire logic       test_voltage_in,
  // Link to the device
  flash_bus_if.host       bus
);
  typedef enum {
    S_IDLE, S_SEL, S_RDPROT, S_ARM, S_NVS, S_HV, S_PGS, S_WR, S_PROG,
    S_HOLD, S_CLRSEL, S_NVH, S_HVOFF, S_RCV, S_READ, S_READ2
  } step_t;

  step_t      step;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [7:0] data;
  logic [7:0] rdata;
  logic       busy;
  logic       load;
  logic [CNT_W-1:0] count;
  logic       done;
  logic [7:0] ctl_val;

  wait_timer #(.WIDTH(CNT_W)) u_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .load    (load),
    .count   (count),
    .done    (done)
  );

  always_comb
  begin
    ctl_val = CTL_RESET;
    if (cmd[6:0] == CMD_PROGRAM[6:0])
      ctl_val[CTL_PROGRAM] = 1'b1;
    else
    begin
      ctl_val[CTL_ERASE] = 1'b1;
      ctl_val[CTL_WHOLE] = (cmd[6:0] == CMD_MASS_ERASE[6:0]);
    end
    load  = 1'b0;
    count = '0;
    case (step)
      S_ARM:    begin load = 1'b1; count = CNT_W'(NVS_N); end
      S_HV:
      begin
        load = 1'b1;
        if (cmd[6:0] == CMD_PROGRAM[6:0])
          count = CNT_W'(PGS_N);
        else if (cmd[6:0] == CMD_MASS_ERASE[6:0])
          count = CNT_W'(MERASE_N);
        else if (cmd[7])
          count = CNT_W'(ELONG_N);
        else
          count = CNT_W'(ESHORT_N);
      end
      S_WR:     begin load = 1'b1; count = CNT_W'(PROG_N); end
      S_CLRSEL:
      begin
        load  = 1'b1;
        count = (cmd[6:0] == CMD_MASS_ERASE[6:0]) ? CNT_W'(NVHL_N) : CNT_W'(NVH_N);
      end
      S_HVOFF:  begin load = 1'b1; count = CNT_W'(RCV_N); end
      default:  begin load = 1'b0; count = '0; end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step <= S_IDLE;
      bus.ctl_we <= 1'b0;
      bus.ctl_wdata <= CTL_RESET;
      bus.arr_we <= 1'b0;
      bus.arr_re <= 1'b0;
      bus.arr_addr <= '0;
      bus.arr_wdata <= '0;
      rdata <= '0;
    end
    else
    begin
      bus.ctl_we <= 1'b0;
      bus.arr_we <= 1'b0;
      bus.arr_re <= 1'b0;
      case (step)
        S_IDLE:
          if (sw_we && sw_addr == REG_CMD)
            step <= (sw_wdata == CMD_READ) ? S_READ : S_SEL;
        S_SEL:
        begin
          bus.ctl_we <= 1'b1;
          bus.ctl_wdata <= ctl_val;
          step <= S_RDPROT;
        end
        S_RDPROT:
        begin
          bus.arr_re <= 1'b1;
          bus.arr_addr <= PROTECT_ADDR;
          step <= S_ARM;
        end
        S_ARM:
        begin
          bus.arr_we <= 1'b1;
          // Monitor-mode mass erase arming goes to the protect byte
          bus.arr_addr <= (cmd[6:0] == CMD_MASS_ERASE[6:0] && test_voltage_in) ?
                          PROTECT_ADDR : addr;
          bus.arr_wdata <= data;
          step <= S_NVS;
        end
        S_NVS:
          if (done)
            step <= S_HV;
        S_HV:
        begin
          bus.ctl_we <= 1'b1;
          bus.ctl_wdata <= ctl_val | (8'h01 << CTL_HV);
          step <= (cmd[6:0] == CMD_PROGRAM[6:0]) ? S_PGS : S_HOLD;
        end
        S_PGS:
          if (done)
            step <= S_WR;
        S_WR:
        begin
          // Software keeps a byte FF-only; one byte per command
          bus.arr_we <= 1'b1;
          bus.arr_addr <= addr;
          bus.arr_wdata <= data;
          step <= S_PROG;
        end
        S_PROG, S_HOLD:
          if (done)
            step <= S_CLRSEL;
        S_CLRSEL:
        begin
          bus.ctl_we <= 1'b1;
          bus.ctl_wdata <= 8'h01 << CTL_HV;
          step <= S_NVH;
        end
        S_NVH:
          if (done)
            step <= S_HVOFF;
        S_HVOFF:
        begin
          bus.ctl_we <= 1'b1;
          bus.ctl_wdata <= CTL_RESET;
          step <= S_RCV;
        end
        S_RCV:
          if (done)
            step <= S_IDLE;
        S_READ:
        begin
          bus.arr_re <= 1'b1;
          bus.arr_addr <= addr;
          step <= S_READ2;
        end
        S_READ2:
        begin
          step <= S_IDLE;
        end
        default: step <= S_IDLE;
      endcase
      if (step == S_IDLE || step == S_RCV || step == S_NVS)
        rdata <= bus.arr_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd  <= '0;
      addr <= '0;
      data <= ERASED_BYTE;
    end
    else if (sw_we && step == S_IDLE)
      case (sw_addr)
        REG_CMD:  cmd <= sw_wdata;
        REG_ADDR: addr <= {addr[7:0], sw_wdata};
        REG_DATA: data <= sw_wdata;
        default:  cmd <= cmd;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      busy <= 1'b0;
    else
      busy <= (step != S_IDLE) || (sw_we && sw_addr == REG_CMD);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      bus.test_high_voltage <= 1'b0;
    else
      bus.test_high_voltage <= test_voltage_in;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sw_rdata <= '0;
    else if (sw_re)
      case (sw_addr)
        REG_STATUS: sw_rdata <= {7'h00, busy};
        REG_RDATA:  sw_rdata <= rdata;
        REG_PROT:   sw_rdata <= bus.ctl_rdata;
        default:    sw_rdata <= '0;
      endcase
    else
      sw_rdata <= '0;
  end
endmodule : flash_host

// ===== hdl/wait_timer.sv
`timescale 1ns/10ps
module wait_timer
  import flash_ctl_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Load and status
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);
  logic [WIDTH-1:0] remain;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      remain <= '0;
    else if (load)
      remain <= count;
    else if (remain != '0)
      remain <= remain - 1'b1;
  end

  assign done = (remain == '0) && !load;
endmodule : wait_timer

// ===== verif/flash_ctl_assertions.sv
`timescale 1ns/10ps
module flash_ctl_assertions
  import flash_ctl_pkg::*;
(
  // Clock and reset
  input logic              ref_clk,
  input logic              rst_b,
  // Control register path
  input logic              ctl_we,
  input logic [7:0]        ctl_wdata,
  input logic [7:0]        ctl_rdata,
  // Array path
  input logic              arr_we,
  input logic              arr_re,
  input logic [ADDR_W-1:0] arr_addr,
  input logic [DATA_W-1:0] arr_wdata,
  input logic [DATA_W-1:0] arr_rdata,
  input logic              test_high_voltage
);
  logic              rd_prot;
  logic [7:0]        prot_q;
  logic [ADDR_W-1:0] arm_addr;

  // ****************************************************************
  // Helper state
  // ****************************************************************
  // Protect byte as the host last read it; that is the value HV is gated on
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_prot <= 1'b0;
      prot_q  <= OPEN_PROTECT;
    end
    else
    begin
      rd_prot <= arr_re && (arr_addr == PROTECT_ADDR);
      if (rd_prot)
        prot_q <= arr_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      arm_addr <= '0;
    else if (arr_we && (ctl_rdata[1:0] != 2'h0) && !ctl_rdata[CTL_HV])
      arm_addr <= arr_addr;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_never_both; !(ctl_rdata[CTL_PROGRAM] && ctl_rdata[CTL_ERASE]); endproperty
  a_never_both: assert property (p_never_both)
    else $error("program and erase selects both set");
  property p_refuse_both;
    ctl_we && (ctl_wdata[1:0] == 2'h3) |=> ctl_rdata[1:0] == $past(ctl_rdata[1:0]);
  endproperty
  a_refuse_both: assert property (p_refuse_both)
    else $error("double select write was taken");
  property p_write_takes;
    ctl_we && (ctl_wdata[1:0] != 2'h3) |=> ctl_rdata[2:0] == $past(ctl_wdata[2:0]);
  endproperty
  a_write_takes: assert property (p_write_takes)
    else $error("legal select write not taken");
  property p_hv_select; $rose(ctl_rdata[CTL_HV]) |-> (ctl_rdata[1:0] != 2'h0); endproperty
  a_hv_select: assert property (p_hv_select)
    else $error("high voltage rose with no select");
  property p_hv_on_write; $rose(ctl_rdata[CTL_HV]) |-> $past(ctl_we); endproperty
  a_hv_on_write: assert property (p_hv_on_write)
    else $error("high voltage rose without a write");
  property p_ctl_reset; $rose(rst_b) |-> ctl_rdata == CTL_RESET; endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("control register not clear after reset");
  property p_mass_blocked;
    $rose(ctl_rdata[CTL_HV]) && ctl_rdata[CTL_WHOLE] && !test_high_voltage
      |-> prot_q == OPEN_PROTECT;
  endproperty
  a_mass_blocked: assert property (p_mass_blocked)
    else $error("mass erase started with a block protected");
  property p_hv_protected;
    $rose(ctl_rdata[CTL_HV]) && !ctl_rdata[CTL_WHOLE] && !test_high_voltage
      |-> (prot_q == OPEN_PROTECT) || (arm_addr < {PROT_HIGH_BITS, prot_q, PROT_LOW_BITS});
  endproperty
  a_hv_protected: assert property (p_hv_protected)
    else $error("high voltage rose on a protected target");
  property p_rdata_hold; !arr_re |=> $stable(arr_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("array read data changed without a read");
endmodule : flash_ctl_assertions

// ===== verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import flash_ctl_pkg::*;
  // Short waits keep the run small; the sequence order is what is tested
  localparam int unsigned W = 4;
  logic        ref_clk, rst_b, sw_we, sw_re, test_voltage_in;
  logic [3:0]  sw_addr;
  logic [7:0]  sw_wdata, sw_rdata, ctl_obs, prot_obs, seed, v;
  logic [15:0] pg;
  logic [15:0] ad [4];
  logic [7:0]  dt [4];
  int          n_errors, n_checks, cyc;

  flash_bus_if flash_bus_if_i ();
  flash_device flash_device_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus(flash_bus_if_i),
    .flash_operation_control(ctl_obs), .protect_start_byte(prot_obs));
  flash_host #(.NVS_N(W), .NVH_N(W), .NVHL_N(W), .PGS_N(W), .PROG_N(W), .RCV_N(W),
    .ESHORT_N(W), .ELONG_N(W), .MERASE_N(W)) flash_host_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata),
    .test_voltage_in(test_voltage_in), .bus(flash_bus_if_i));
  flash_ctl_assertions flash_ctl_assertions_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .ctl_we(flash_bus_if_i.ctl_we), .ctl_wdata(flash_bus_if_i.ctl_wdata),
    .ctl_rdata(flash_bus_if_i.ctl_rdata), .arr_we(flash_bus_if_i.arr_we),
    .arr_re(flash_bus_if_i.arr_re), .arr_addr(flash_bus_if_i.arr_addr),
    .arr_wdata(flash_bus_if_i.arr_wdata), .arr_rdata(flash_bus_if_i.arr_rdata),
    .test_high_voltage(flash_bus_if_i.test_high_voltage));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  // Programming can only pull bits from one to zero
  function automatic logic [7:0] exp_prog(logic [7:0] old, logic [7:0] d);
    return old & d;
  endfunction : exp_prog

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic sw_wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_we    <= 1'b1;
    @(posedge ref_clk);
    sw_we    <= 1'b0;
  endtask : sw_wr

  task automatic sw_rd(logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_re   <= 1'b1;
    @(posedge ref_clk);
    sw_re   <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_rd

  // Busy polling is cut short by the global timeout
  task automatic run_cmd(logic [15:0] a, logic [7:0] d, logic [7:0] c);
    logic [7:0] s;
    sw_wr(REG_ADDR, a[15:8]);
    sw_wr(REG_ADDR, a[7:0]);
    sw_wr(REG_DATA, d);
    sw_wr(REG_CMD, c);
    do sw_rd(REG_STATUS, s); while (s[0] !== 1'b0);
  endtask : run_cmd

  task automatic rd_arr(logic [15:0] a, output logic [7:0] d);
    run_cmd(a, 8'h00, CMD_READ);
    sw_rd(REG_RDATA, d);
  endtask : rd_arr

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Clock and timeout
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      print_verdict;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    {rst_b, sw_we, sw_re, test_voltage_in} = 4'h0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    seed = 8'h12;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk(ctl_obs, CTL_RESET);
    chk(prot_obs, OPEN_PROTECT);
    seed = lfsr_next(seed);
    pg = 16'he400 + {6'h00, seed[3:0], 6'h00};
    run_cmd(pg, 8'h00, CMD_PAGE_ERASE);
    run_cmd(pg + 16'h0040, 8'h00, CMD_PAGE_ERASE | CMD_LONG_ERASE);
    rd_arr(pg + 16'h003f, v); chk(v, ERASED_BYTE);
    rd_arr(pg + 16'h0040, v); chk(v, ERASED_BYTE);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr_next(seed);
      ad[i] = pg + 16'(i * ROW_BYTES) + {11'h000, seed[4:0]};
      seed = lfsr_next(seed);
      dt[i] = seed & 8'h7e;
      run_cmd(ad[i], dt[i], CMD_PROGRAM);
      rd_arr(ad[i], v); chk(v, exp_prog(ERASED_BYTE, dt[i]));
    end
    // Only the first page goes; the neighbour page keeps its bytes
    run_cmd(pg, 8'h00, CMD_PAGE_ERASE);
    for (int i = 0; i < 4; i++)
    begin
      rd_arr(ad[i], v); chk(v, (i < 2) ? ERASED_BYTE : dt[i]);
    end
    run_cmd(ARRAY_BASE, 8'h00, CMD_MASS_ERASE);
    rd_arr(ad[3], v); chk(v, ERASED_BYTE);
    run_cmd(PROTECT_ADDR, 8'hfe, CMD_PROGRAM);
    chk(prot_obs, 8'hfe);
    run_cmd(16'hff80, 8'h00, CMD_PROGRAM);
    rd_arr(16'hff80, v); chk(v, ERASED_BYTE);
    run_cmd(16'hff40, 8'h5a, CMD_PROGRAM);
    rd_arr(16'hff40, v); chk(v, 8'h5a);
    run_cmd(ARRAY_BASE, 8'h00, CMD_MASS_ERASE);
    rd_arr(16'hff40, v); chk(v, 8'h5a);
    run_cmd(PROTECT_ADDR, 8'h00, CMD_PROGRAM);
    chk(prot_obs, 8'hfe);
    @(posedge ref_clk);
    test_voltage_in <= 1'b1;
    run_cmd(PROTECT_ADDR, 8'h00, CMD_MASS_ERASE);
    @(posedge ref_clk);
    test_voltage_in <= 1'b0;
    chk(prot_obs, OPEN_PROTECT);
    rd_arr(16'hff40, v); chk(v, ERASED_BYTE);
    run_cmd(PROTECT_ADDR, 8'h00, CMD_PROGRAM);
    chk(prot_obs, 8'h00);
    run_cmd(ad[0], 8'h00, CMD_PROGRAM);
    rd_arr(ad[0], v); chk(v, ERASED_BYTE);
    // Reset lands while high voltage is on in an erase
    @(posedge ref_clk);
    test_voltage_in <= 1'b1;
    sw_wr(REG_CMD, CMD_PAGE_ERASE);
    repeat (10) @(posedge ref_clk);
    sw_rd(REG_PROT, v); chk(v, 8'((1 << CTL_ERASE) | (1 << CTL_HV)));
    @(posedge ref_clk);
    rst_b <= 1'b0;
    test_voltage_in <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk(ctl_obs, CTL_RESET);
    sw_rd(REG_STATUS, v); chk(v, 8'h00);
    print_verdict;
  end
endmodule : tb_top
